// File: src/cpcrc_ctrl.sv
// design: chipset clock gating, reset sequencing and power state control
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cpcrc_ctrl
  import cpcrc_pkg::*;
#(
  parameter int TMR_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic power_ok_reset_n,
  input wire logic low_battery,
  input wire logic very_low_battery,
  input wire logic mains_present_input,
  input wire logic wake_event,
  input wire cpcrc_pkg::cpcrc_bus_req_t bus_req,
  output logic [cpcrc_pkg::DATA_W-1:0] rd_data,
  output logic processor_base_clock,
  output logic isa_bus_clock,
  output logic processor_reset_out,
  output logic expansion_bus_reset,
  output logic power_mgmt_interrupt,
  output logic [cpcrc_pkg::PC_W-1:0] power_out,
  output cpcrc_pkg::cpcrc_board_t board_ctrl,
  output logic [2:0] pm_inputs
);
  import cpcrc_pkg::*;

  // elaboration checks: values the logic below cannot serve
  if (TMR_W < 1 || TMR_W > DATA_W) begin : g_bad_tmr_w
    $error("TMR_W out of range");
  end
  if (CPU_RST_CYCLES < 1 || CPU_RST_CYCLES > 31) begin : g_bad_rst
    $error("reset stretch does not fit its counter");
  end
  if (DIV_SLOW < 3'h2 || DIV_FAST < 3'h2) begin : g_bad_div
    $error("bus clock ratio below two");
  end

  // power-ok and battery pins come from outside the clock domain
  logic pok_s1_r;
  logic pok_s2_r;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  always_ff @(posedge clk) begin
    pok_s1_r <= power_ok_reset_n;
    pok_s2_r <= pok_s1_r;
  end
  // pins sampled as one group: {mains, very low, low}
  always_ff @(posedge clk) begin
    pin_s1_r <= {mains_present_input, very_low_battery, low_battery};
    pin_s2_r <= pin_s1_r;
  end

  // wake pin, level sensitive
  logic wake_s1_r;
  logic wake_s2_r;
  always_ff @(posedge clk) begin
    wake_s1_r <= wake_event;
    wake_s2_r <= wake_s1_r;
  end

  // system reset while power-ok is low; clocks and read data reset on srst alone
  logic sys_rst;
  assign sys_rst = srst | ~pok_s2_r;

  // one power control word per state, indexed by state_idx
  logic [PC_W-1:0] pc_regs_r [4];
  // only the input enable bit has a use
  logic [7:0] pm_in_en_r;
  // {force, auto, isa reset}
  logic [2:0] pm_ctrl_r;
  logic [TMR_W-1:0] tmr_limit_r;
  logic clk_cfg_r;
  cpcrc_pstate_t pstate_r;
  logic [TMR_W-1:0] tmr_r;
  logic irq_r;

  // an illegal state code falls back to the full-on word
  function automatic logic [1:0] state_idx(input cpcrc_pstate_t s);
    unique case (s)
      PS_FULL_ON: begin
        state_idx = 2'd0;
      end
      PS_DOZE: begin
        state_idx = 2'd1;
      end
      PS_SLEEP: begin
        state_idx = 2'd2;
      end
      PS_SUSPEND: begin
        state_idx = 2'd3;
      end
      default: begin
        state_idx = 2'd0;
      end
    endcase
  endfunction

  // register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        pc_regs_r[i] <= PC_RESET_VAL;
      end
      pm_in_en_r <= PM_IN_RESET_VAL;
      // isa reset bit comes up set, so bus devices stay in reset
      pm_ctrl_r <= 3'h1;
      tmr_limit_r <= TMR_RESET_VAL[TMR_W-1:0];
      clk_cfg_r <= 1'b0;
    end else begin
      // force is a one-cycle strobe; a write below may set it again
      pm_ctrl_r[CTRL_FORCE_BIT] <= 1'b0;
      if (bus_req.wr) begin
        unique case (bus_req.addr)
          OFF_FULL_ON: begin
            pc_regs_r[0] <= bus_req.wdata[PC_W-1:0];
          end
          OFF_DOZE: begin
            pc_regs_r[1] <= bus_req.wdata[PC_W-1:0];
          end
          OFF_SLEEP: begin
            pc_regs_r[2] <= bus_req.wdata[PC_W-1:0];
          end
          OFF_SUSPEND: begin
            pc_regs_r[3] <= bus_req.wdata[PC_W-1:0];
          end
          OFF_PM_INPUT_EN: begin
            pm_in_en_r <= bus_req.wdata[7:0];
          end
          OFF_PM_CTRL: begin
            pm_ctrl_r <= bus_req.wdata[2:0];
          end
          OFF_STATE_TMR: begin
            tmr_limit_r <= bus_req.wdata[TMR_W-1:0];
          end
          OFF_CLK_CFG: begin
            clk_cfg_r <= bus_req.wdata[CFG_SLOW_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read data one cycle after the strobe, zero for unmapped offsets
  logic [DATA_W-1:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    unique case (bus_req.addr)
      OFF_FULL_ON: begin
        rd_nxt[PC_W-1:0] = pc_regs_r[0];
      end
      OFF_DOZE: begin
        rd_nxt[PC_W-1:0] = pc_regs_r[1];
      end
      OFF_SLEEP: begin
        rd_nxt[PC_W-1:0] = pc_regs_r[2];
      end
      OFF_SUSPEND: begin
        rd_nxt[PC_W-1:0] = pc_regs_r[3];
      end
      OFF_PM_INPUT_EN: begin
        rd_nxt[7:0] = pm_in_en_r;
      end
      OFF_PM_CTRL: begin
        rd_nxt[2:0] = pm_ctrl_r;
      end
      OFF_STATE_TMR: begin
        rd_nxt[TMR_W-1:0] = tmr_limit_r;
      end
      OFF_STATUS: begin
        // pins [8:6], irq [5], one-hot state [4:1]
        rd_nxt[8:0] = {pin_s2_r, irq_r, pstate_r, 1'b0};
      end
      OFF_CLK_CFG: begin
        rd_nxt[0] = clk_cfg_r;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end
  // zero between reads keeps the read path quiet
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (bus_req.rd) begin
      rd_data <= rd_nxt;
    end else begin
      rd_data <= '0;
    end
  end

  // a status read clears the interrupt
  logic irq_clr;
  assign irq_clr = bus_req.rd && bus_req.addr == OFF_STATUS;

  // state timer; limit zero disables it
  logic tmr_hit;
  assign tmr_hit = tmr_limit_r != '0 && tmr_r == tmr_limit_r;
  // full-on only counts with auto advance; wake restarts the count
  always_ff @(posedge clk) begin
    if (sys_rst || wake_s2_r || tmr_hit) begin
      tmr_r <= '0;
    end else if (pstate_r != PS_FULL_ON) begin
      tmr_r <= tmr_r + 1'b1;
    end else if (pm_ctrl_r[CTRL_AUTO_BIT]) begin
      tmr_r <= tmr_r + 1'b1;
    end else begin
      tmr_r <= '0;
    end
  end

  // suspend holds; only wake or reset leaves it
  function automatic cpcrc_pstate_t next_state(input cpcrc_pstate_t s);
    unique case (s)
      PS_FULL_ON: begin
        next_state = PS_DOZE;
      end
      PS_DOZE: begin
        next_state = PS_SLEEP;
      end
      PS_SLEEP: begin
        next_state = PS_SUSPEND;
      end
      PS_SUSPEND: begin
        next_state = PS_SUSPEND;
      end
      default: begin
        next_state = PS_FULL_ON;
      end
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst || wake_s2_r) begin
      pstate_r <= PS_FULL_ON;
    end else if (pm_ctrl_r[CTRL_FORCE_BIT]) begin
      pstate_r <= next_state(pstate_r);
    end else if (tmr_hit && pm_ctrl_r[CTRL_AUTO_BIT]) begin
      pstate_r <= next_state(pstate_r);
    end
  end

  // expiry without auto-advance raises the interrupt; set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else if (tmr_hit && !pm_ctrl_r[CTRL_AUTO_BIT]) begin
      irq_r <= 1'b1;
    end else if (irq_clr) begin
      irq_r <= 1'b0;
    end
  end
  assign power_mgmt_interrupt = irq_r;

  // processor reset stretched a fixed count past power-ok release
  logic [4:0] rst_cnt_r;
  logic rst_done;
  assign rst_done = rst_cnt_r == 5'(CPU_RST_CYCLES);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_cnt_r <= '0;
    end else if (!rst_done) begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end
  end
  // counter saturates, so the reset never comes back on its own
  always_ff @(posedge clk) begin
    processor_reset_out <= sys_rst || !rst_done;
  end
  // bus devices see the system reset as well as the register bit
  always_ff @(posedge clk) begin
    expansion_bus_reset <= sys_rst || pm_ctrl_r[CTRL_ISA_RST_BIT];
  end

  // gated processor clock: divide-by-two toggle, parked low in suspend
  logic cpu_clk_r;
  always_ff @(posedge clk) begin
    if (srst || pstate_r == PS_SUSPEND) begin
      cpu_clk_r <= 1'b0;
    end else begin
      cpu_clk_r <= ~cpu_clk_r;
    end
  end
  // a flop output, so the gate cannot glitch on a state change
  assign processor_base_clock = cpu_clk_r;

  // bus clock divider; ratio latched only at wrap so no short pulse
  logic [2:0] div_cnt_r;
  logic [2:0] div_ratio_r;
  logic [2:0] ratio_sel;
  logic div_wrap;
  assign ratio_sel = clk_cfg_r ? DIV_SLOW : DIV_FAST;
  assign div_wrap = div_cnt_r == div_ratio_r - 3'h1;
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_r <= '0;
    end else if (div_wrap) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end
  // a new ratio only ever starts a fresh period
  always_ff @(posedge clk) begin
    if (srst) begin
      div_ratio_r <= DIV_FAST;
    end else if (div_wrap) begin
      div_ratio_r <= ratio_sel;
    end
  end
  // high for the first half of the period, the shorter half when odd
  always_ff @(posedge clk) begin
    if (srst) begin
      isa_bus_clock <= 1'b0;
    end else begin
      isa_bus_clock <= div_cnt_r < (div_ratio_r >> 1);
    end
  end

  // active state's register drives the lines; unused lines held low
  logic [1:0] st_idx;
  assign st_idx = state_idx(pstate_r);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_out <= PC_RESET_VAL & PC_USED_MASK;
    end else begin
      power_out <= pc_regs_r[st_idx] & PC_USED_MASK;
    end
  end
  // board pins are plain copies; level meaning is set by software
  always_comb begin
    board_ctrl.com1_driver_enable = power_out[0];
    board_ctrl.serial_chip_shutdown_n = power_out[1];
    board_ctrl.video_osc_enable = power_out[5];
    board_ctrl.com2_driver_enable = power_out[6];
    board_ctrl.video_suspend_ctrl = power_out[8];
    board_ctrl.diag_led_disable_n = power_out[9];
  end

  // battery and mains reach the manager only when enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pm_inputs <= '0;
    end else if (pm_in_en_r[PM_IN_EN_BIT]) begin
      pm_inputs <= pin_s2_r;
    end else begin
      pm_inputs <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// File: pkg/cpcrc_pkg.sv
// package: constants and types for the power, clock and reset controller
package cpcrc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int PC_W = 10;
  localparam logic [11:0] OFF_FULL_ON = 12'h009;
  localparam logic [11:0] OFF_DOZE = 12'h00A;
  localparam logic [11:0] OFF_SLEEP = 12'h00B;
  localparam logic [11:0] OFF_SUSPEND = 12'h00C;
  localparam logic [11:0] OFF_PM_INPUT_EN = 12'h110;
  localparam logic [11:0] OFF_PM_CTRL = 12'h120;
  localparam logic [11:0] OFF_STATE_TMR = 12'h121;
  localparam logic [11:0] OFF_STATUS = 12'h122;
  localparam logic [11:0] OFF_CLK_CFG = 12'h123;
  localparam int PM_IN_EN_BIT = 4;
  localparam int CTRL_ISA_RST_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_FORCE_BIT = 2;
  localparam int CFG_SLOW_BIT = 0;
  localparam logic [9:0] PC_RESET_VAL = 10'h3FF;
  localparam logic [7:0] PM_IN_RESET_VAL = 8'h00;
  localparam logic [15:0] TMR_RESET_VAL = 16'h0000;
  localparam int CPU_RST_CYCLES = 16;
  localparam logic [2:0] DIV_FAST = 3'h4;
  localparam logic [2:0] DIV_SLOW = 3'h3;
  // mask of lines that drive board functions; 2,3,4,7 are multiplexed away
  localparam logic [9:0] PC_USED_MASK = 10'h363;
  typedef enum logic [3:0] {
    PS_FULL_ON = 4'h1,
    PS_DOZE = 4'h2,
    PS_SLEEP = 4'h4,
    PS_SUSPEND = 4'h8
  } cpcrc_pstate_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpcrc_bus_req_t;
  typedef struct packed {
    logic com1_driver_enable;
    logic serial_chip_shutdown_n;
    logic video_osc_enable;
    logic com2_driver_enable;
    logic video_suspend_ctrl;
    logic diag_led_disable_n;
  } cpcrc_board_t;
endpackage

// File: tb/cpcrc_chk.sv
// checker: port-level properties of the controller
`timescale 1ns/1ps
`default_nettype none
module cpcrc_chk
  import cpcrc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic power_ok_reset_n,
  input wire logic processor_base_clock,
  input wire logic isa_bus_clock,
  input wire logic processor_reset_out,
  input wire logic expansion_bus_reset,
  input wire logic power_mgmt_interrupt,
  input wire logic [cpcrc_pkg::PC_W-1:0] power_out,
  input wire cpcrc_pkg::cpcrc_board_t board_ctrl,
  input wire logic [2:0] pm_inputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_srst_all_outs: assert property (disable iff (1'b0)
    srst |=> processor_reset_out && expansion_bus_reset &&
    !power_mgmt_interrupt && pm_inputs == 3'h0 &&
    power_out == PC_USED_MASK) else $error("outputs not in reset");
  a_pok_low_reset: assert property (!power_ok_reset_n [*4] |=>
    processor_reset_out && expansion_bus_reset)
    else $error("power-ok low without reset");
  a_cpu_rst_stretch: assert property ($fell(processor_reset_out) |->
    $past(processor_reset_out, 16)) else $error("cpu reset too short");
  a_cpu_clk_toggle: assert property (processor_base_clock |=>
    !processor_base_clock) else $error("cpu clock high twice");
  a_isa_min_period: assert property ($rose(isa_bus_clock) |->
    ##1 !$rose(isa_bus_clock) ##1 !$rose(isa_bus_clock))
    else $error("bus clock too fast");
  a_isa_max_period: assert property ($rose(isa_bus_clock) |->
    ##[3:4] $rose(isa_bus_clock)) else $error("bus clock period wrong");
  a_unused_lines: assert property (
    (power_out & ~PC_USED_MASK) == 10'h000) else $error("unused line set");
  a_board_mapping: assert property (board_ctrl ==
    {power_out[0], power_out[1], power_out[5], power_out[6],
    power_out[8], power_out[9]}) else $error("board map wrong");
  c_irq: cover property ($rose(power_mgmt_interrupt));
  c_cpu_run: cover property ($fell(processor_reset_out));
  c_pm_in: cover property (pm_inputs != 3'h0);
endmodule
bind cpcrc_ctrl cpcrc_chk chk_i (.*);
`default_nettype wire

// File: tb/cpcrc_sup.sv
// supervisor model: power-ok pin with a timed low hold
`timescale 1ns/1ps
`default_nettype none
module cpcrc_sup #(
  parameter int HOLD = 20
) (
  input wire logic clk,
  input wire logic press,
  output logic power_ok_reset_n
);
  int cnt_r = 0;
  // clock runs before release, logic loads first
  always @(posedge clk) begin
    if (press) cnt_r <= HOLD; // hold shortened from ms
    else if (cnt_r > 0) cnt_r <= cnt_r - 1;
  end
  assign power_ok_reset_n = (cnt_r == 0);
endmodule
`default_nettype wire

// File: tb/cpcrc_ctrl_tb_top.sv
// testbench: self-checking run of the power and reset controller
`timescale 1ns/1ps
`default_nettype none
module cpcrc_ctrl_tb_top;
  import cpcrc_pkg::*;
  logic clk = 0, srst = 1, wake_event = 0, press = 0, rd_d = 0;
  logic low_battery = 0, very_low_battery = 0, mains_present_input = 0;
  logic processor_base_clock, isa_bus_clock, processor_reset_out;
  logic expansion_bus_reset, power_mgmt_interrupt;
  logic [15:0] rd_data, v [4];
  logic [15:0] exp_q [$];
  logic [9:0] power_out;
  logic [2:0] pm_inputs, p;
  wire logic power_ok_reset_n;
  cpcrc_bus_req_t bus_req = '0;
  cpcrc_board_t board_ctrl;
  int error_cnt = 0, n_compared = 0, i, k;
  always #2.5 clk = ~clk;
  cpcrc_sup sup (.*);
  cpcrc_ctrl dut (.*);
  task automatic ck(input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("compared %0d bad %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic to;
    error_cnt++;
    final_report;
  endtask
  // strobe then a free edge, so no signal is driven twice in one step
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic per(output int n);
    int t;
    for (t = 0; t < 9 && isa_bus_clock !== 0; t++) @(posedge clk);
    for (t = 0; t < 9 && isa_bus_clock !== 1; t++) @(posedge clk);
    for (n = 0; n < 9 && isa_bus_clock === 1; n++) @(posedge clk);
    for (t = 0; t < 9 && isa_bus_clock === 0; t++) begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    rd_d <= bus_req.rd;
    if (rd_d) ck(rd_data, exp_q.pop_front());
  end
  initial begin
    k = $urandom(32'hFD721341);
    repeat (12) @(posedge clk);
    srst <= 0;
    for (k = 0; k < 40 && processor_reset_out !== 0; k++) @(posedge clk);
    if (k == 40) to();
    ck(power_out, PC_USED_MASK);
    ck(expansion_bus_reset, 1);
    rd(12'h0FF, 16'h0000);
    rd(OFF_PM_INPUT_EN, 16'h0000);
    for (i = 0; i < 4; i++) rd(12'(OFF_FULL_ON + i), 16'h03FF);
    for (i = 0; i < 4; i++) begin
      v[i] = 16'($urandom) & 16'h03FF;
      wr(12'(OFF_FULL_ON + i), v[i]);
    end
    for (i = 0; i < 4; i++) rd(12'(OFF_FULL_ON + i), v[i]);
    ck(power_out, v[0] & PC_USED_MASK);
    for (i = 1; i < 4; i++) begin
      wr(OFF_PM_CTRL, 16'h0004);
      repeat (2) @(posedge clk);
      ck(power_out, v[i] & PC_USED_MASK);
    end
    ck(expansion_bus_reset, 0);
    repeat (4) begin
      @(posedge clk);
      ck(processor_base_clock, 0);
    end
    wake_event <= 1;
    repeat (6) @(posedge clk);
    wake_event <= 0;
    rd(OFF_STATUS, 16'h0002);
    wr(OFF_STATE_TMR, 16'h0010);
    wr(OFF_PM_CTRL, 16'h0004);
    for (k = 0; k < 40 && power_mgmt_interrupt !== 1; k++) @(posedge clk);
    if (k == 40) to();
    rd(OFF_STATUS, 16'h0024);
    ck(power_mgmt_interrupt, 0);
    wr(OFF_PM_CTRL, 16'h0002);
    for (k = 0; k < 40 && power_out !== (v[2] & PC_USED_MASK); k++)
      @(posedge clk);
    if (k == 40) to();
    wr(OFF_STATE_TMR, 16'h0000);
    p = 3'($urandom) | 3'h1;
    {mains_present_input, very_low_battery, low_battery} <= p;
    repeat (5) @(posedge clk);
    ck(pm_inputs, 0);
    wr(OFF_PM_INPUT_EN, 16'h0010);
    repeat (5) @(posedge clk);
    ck(pm_inputs, p);
    for (i = 0; i < 2; i++) begin
      wr(OFF_CLK_CFG, 16'(i));
      repeat (12) @(posedge clk);
      per(k);
      ck(16'(k), i ? DIV_SLOW : DIV_FAST);
    end
    press <= 1;
    @(posedge clk);
    press <= 0;
    repeat (8) @(posedge clk);
    ck(processor_reset_out, 1);
    for (k = 0; k < 80 && processor_reset_out !== 0; k++) @(posedge clk);
    if (k == 80) to();
    rd(OFF_FULL_ON, 16'h03FF);
    final_report;
  end
endmodule
`default_nettype wire
